/* File: hw/amss_monitor.sv */
// Analog monitor select and scale block with its sample FIFO
//
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module amss_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData,
	output logic [$clog2(DEPTH):0] level
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0]      wrPtr;
	logic [PW:0]      rdPtr;
	logic             pushing;
	logic             popping;

	assign level    = wrPtr - rdPtr;
	assign inReady  = (level != (PW+1)'(DEPTH));
	assign outValid = (wrPtr != rdPtr);
	assign outData  = mem[rdPtr[PW-1:0]];
	assign pushing  = inValid && inReady;
	assign popping  = outValid && outReady;

	always_ff @(posedge ref_clk) begin
		if (pushing) begin
			mem[wrPtr[PW-1:0]] <= inData;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr <= '0;
		end else if (pushing) begin
			wrPtr <= wrPtr + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdPtr <= '0;
		end else if (popping) begin
			rdPtr <= rdPtr + 1'b1;
		end
	end
endmodule : amss_fifo

////////////////////////////////////////////////////////////////////////////////
module amss_monitor #(
	parameter int FIFO_DEPTH    = 8,
	parameter int UPDATE_CYCLES = amss_pkg::UPDATE_CYCLES
) (
	input  wire logic               ref_clk,
	input  wire logic               reset_n,
	// AXI4-Lite slave
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// Monitored drive signals, same clock
	input  wire logic signed [15:0] motorSpeed,
	input  wire logic signed [15:0] speedRef,
	input  wire logic signed [15:0] torqueRef,
	input  wire logic signed [15:0] positionError,
	input  wire logic signed [15:0] positionAmpError,
	input  wire logic signed [15:0] positionRefSpeed,
	input  wire logic signed [15:0] loadPositionError,
	input  wire logic signed [15:0] speedFeedforward,
	input  wire logic signed [15:0] torqueFeedforward,
	input  wire logic signed [15:0] externalSpeed,
	input  wire logic               positioningDone,
	input  wire logic               referenceDone,
	input  wire logic               secondGainActive,
	input  wire logic               positionControl,
	input  wire logic               fullyClosedLoop,
	// Output converter: code one in [15:0], code two in [31:16]
	output logic                    dacValid,
	input  wire logic               dacReady,
	output logic [31:0]             dacCodes
);
	localparam int CH = 2;

	logic [15:0]        selReg  [CH];
	logic signed [15:0] offsReg [CH];
	logic signed [15:0] multReg [CH];
	logic signed [15:0] code    [CH];
	logic [31:0]        lastCodes;
	logic [31:0]        updateCount;
	logic               samplePending;
	logic               fifoInReady;
	logic [$clog2(FIFO_DEPTH):0] fifoLevel;

	////////////////////////////////////////////////////////////////////////////
	// Register bus: address and data taken in either order
	logic        awHeld;
	logic        wHeld;
	logic [7:0]  awAddr;
	logic [31:0] wData;
	logic [3:0]  wStrb;
	logic        doWrite;
	logic        wrMapped;

	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld && !s_axi_bvalid;
	assign doWrite       = awHeld && wHeld && !s_axi_bvalid;
	assign wrMapped      = (awAddr <= amss_pkg::ADDR_MULT_TWO) &&
	                       (awAddr[1:0] == 2'b00);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld <= 1'b0;
			awAddr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wHeld <= 1'b0;
			wData <= '0;
			wStrb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= amss_pkg::RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wrMapped ? amss_pkg::RESP_OKAY
			                         : amss_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Byte lanes merged into a 16-bit setting
	function automatic logic [15:0] merge(input logic [15:0] old,
	                                      input logic [31:0] data,
	                                      input logic [3:0]  strb);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = data[7:0];
		end
		if (strb[1]) begin
			v[15:8] = data[15:8];
		end
		return v;
	endfunction : merge

	// Out-of-range settings are held at the nearest limit
	function automatic logic signed [15:0] clampSet(input logic [15:0] v);
		logic signed [15:0] s;
		s = signed'(v);
		if (s > amss_pkg::SET_MAX) begin
			return amss_pkg::SET_MAX;
		end
		if (s < amss_pkg::SET_MIN) begin
			return amss_pkg::SET_MIN;
		end
		return s;
	endfunction : clampSet

	////////////////////////////////////////////////////////////////////////////
	// Per-channel settings and scaling
	genvar g;
	generate
		for (g = 0; g < CH; g++) begin : gChan
			localparam logic [7:0] A_SEL  = g ? amss_pkg::ADDR_SEL_TWO
			                                  : amss_pkg::ADDR_SEL_ONE;
			localparam logic [7:0] A_OFFS = g ? amss_pkg::ADDR_OFFS_TWO
			                                  : amss_pkg::ADDR_OFFS_ONE;
			localparam logic [7:0] A_MULT = g ? amss_pkg::ADDR_MULT_TWO
			                                  : amss_pkg::ADDR_MULT_ONE;
			localparam logic [15:0] SEL_INIT = g ? amss_pkg::SEL_TWO_RESET
			                                     : amss_pkg::SEL_ONE_RESET;
			logic signed [31:0] signalMv;
			logic signed [47:0] sum;
			logic signed [63:0] scaled;
			logic signed [47:0] shifted;

			// Own selection per channel, with its reset choice
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					selReg[g] <= SEL_INIT;
				end else if (doWrite && awAddr == A_SEL) begin
					selReg[g] <= merge(selReg[g], wData, wStrb);
				end
			end

			// Own offset and multiplier per channel
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					offsReg[g] <= signed'(amss_pkg::OFFS_RESET);
					multReg[g] <= signed'(amss_pkg::MULT_RESET);
				end else if (doWrite && awAddr == A_OFFS) begin
					offsReg[g] <= clampSet(merge(offsReg[g], wData, wStrb));
				end else if (doWrite && awAddr == A_MULT) begin
					multReg[g] <= clampSet(merge(multReg[g], wData, wStrb));
				end
			end

			// Selected signal in millivolts; unknown and reserved codes give 0 V
			// Signed zero keeps gated products signed, so negatives stay negative
			always_comb begin
				signalMv = '0;
				case (selReg[g][7:0])
					amss_pkg::SEL_SPEED:
						signalMv = motorSpeed * amss_pkg::MV_PER_RPM;
					amss_pkg::SEL_SPEED_REF:
						signalMv = speedRef * amss_pkg::MV_PER_RPM;
					amss_pkg::SEL_TORQUE_REF:
						signalMv = torqueRef * amss_pkg::MV_PER_TORQUE;
					amss_pkg::SEL_POS_ERR:
						signalMv = positionControl ?
							positionError * amss_pkg::MV_PER_REF_UNIT : 32'sh0;
					amss_pkg::SEL_AMP_ERR:
						signalMv = positionAmpError * amss_pkg::MV_PER_PULSE;
					amss_pkg::SEL_POS_REF_SP:
						signalMv = positionRefSpeed * amss_pkg::MV_PER_RPM;
					amss_pkg::SEL_RESERVED:
						signalMv = '0;
					amss_pkg::SEL_LOAD_ERR:
						signalMv = loadPositionError *
							amss_pkg::MV_PER_LOAD_REF;
					amss_pkg::SEL_POS_DONE:
						signalMv = positioningDone ?
							amss_pkg::MV_LEVEL_HIGH : '0;
					amss_pkg::SEL_SPEED_FF:
						signalMv = speedFeedforward * amss_pkg::MV_PER_RPM;
					amss_pkg::SEL_TORQUE_FF:
						signalMv = torqueFeedforward *
							amss_pkg::MV_PER_TORQUE;
					amss_pkg::SEL_GAIN_SET:
						signalMv = secondGainActive ? amss_pkg::MV_GAIN_TWO
						                            : amss_pkg::MV_GAIN_ONE;
					amss_pkg::SEL_REF_DONE:
						signalMv = referenceDone ?
							amss_pkg::MV_LEVEL_HIGH : '0;
					amss_pkg::SEL_EXT_SPEED:
						signalMv = fullyClosedLoop ?
							externalSpeed * amss_pkg::MV_PER_RPM : 32'sh0;
					default:
						signalMv = '0;
				endcase
			end

			// Sum in 0.01 mV, negated, then turned into a code
			always_comb begin
				sum = 48'(signalMv) * 48'(multReg[g]) +
				      48'(offsReg[g]) * 48'(amss_pkg::OFFS_STEP_CMV);
				scaled = -(64'(sum) * 64'(amss_pkg::CODE_GAIN));
				shifted = 48'(scaled >>> amss_pkg::CODE_SHIFT);
				if (shifted > 48'(amss_pkg::CODE_MAX)) begin
					code[g] = amss_pkg::CODE_MAX;
				end else if (shifted < 48'(amss_pkg::CODE_MIN)) begin
					code[g] = amss_pkg::CODE_MIN;
				end else begin
					code[g] = shifted[15:0];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Update pacing; a full FIFO holds the sample until room appears
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			updateCount <= '0;
		end else if (updateCount == 32'(UPDATE_CYCLES - 1)) begin
			updateCount <= '0;
		end else begin
			updateCount <= updateCount + 32'h00000001;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			samplePending <= 1'b0;
		end else if (updateCount == 32'(UPDATE_CYCLES - 1)) begin
			samplePending <= 1'b1;
		end else if (fifoInReady) begin
			samplePending <= 1'b0;
		end
	end

	// Codes are taken at the push, so any setting written before it counts
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			lastCodes <= '0;
		end else if (samplePending && fifoInReady) begin
			lastCodes <= {code[1], code[0]};
		end
	end

	amss_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) uFifo (
		.ref_clk  (ref_clk),
		.reset_n  (reset_n),
		.inValid  (samplePending),
		.inReady  (fifoInReady),
		.inData   ({code[1], code[0]}),
		.outValid (dacValid),
		.outReady (dacReady),
		.outData  (dacCodes),
		.level    (fifoLevel)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register reads
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= amss_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= amss_pkg::RESP_OKAY;
			case (s_axi_araddr)
				amss_pkg::ADDR_SEL_ONE:    s_axi_rdata <= {16'h0000, selReg[0]};
				amss_pkg::ADDR_SEL_TWO:    s_axi_rdata <= {16'h0000, selReg[1]};
				amss_pkg::ADDR_OFFS_ONE:   s_axi_rdata <= {16'h0000, offsReg[0]};
				amss_pkg::ADDR_OFFS_TWO:   s_axi_rdata <= {16'h0000, offsReg[1]};
				amss_pkg::ADDR_MULT_ONE:   s_axi_rdata <= {16'h0000, multReg[0]};
				amss_pkg::ADDR_MULT_TWO:   s_axi_rdata <= {16'h0000, multReg[1]};
				amss_pkg::ADDR_LAST_CODES: s_axi_rdata <= lastCodes;
				amss_pkg::ADDR_STATUS:
					s_axi_rdata <= {samplePending,
					                31'(fifoLevel)};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= amss_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : amss_monitor

`default_nettype wire

/* File: hw/amss_pkg.sv */
// Constants shared by the analog monitor select and scale block
package amss_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_SEL_ONE    = 8'h00;
	localparam logic [7:0] ADDR_SEL_TWO    = 8'h04;
	localparam logic [7:0] ADDR_OFFS_ONE   = 8'h08;
	localparam logic [7:0] ADDR_OFFS_TWO   = 8'h0c;
	localparam logic [7:0] ADDR_MULT_ONE   = 8'h10;
	localparam logic [7:0] ADDR_MULT_TWO   = 8'h14;
	localparam logic [7:0] ADDR_LAST_CODES = 8'h18;
	localparam logic [7:0] ADDR_STATUS     = 8'h1c;
	localparam int         ADDR_BITS       = 8;

	// Reset values
	localparam logic [15:0] SEL_ONE_RESET = 16'h0002;
	localparam logic [15:0] SEL_TWO_RESET = 16'h0000;
	localparam logic [15:0] OFFS_RESET    = 16'h0000;
	localparam logic [15:0] MULT_RESET    = 16'h0064;

	// Accepted setting range of offset and multiplier
	localparam logic signed [15:0] SET_MAX = 16'sh2710;
	localparam logic signed [15:0] SET_MIN = -16'sh2710;

	// Selection codes
	localparam logic [7:0] SEL_SPEED      = 8'h00;
	localparam logic [7:0] SEL_SPEED_REF  = 8'h01;
	localparam logic [7:0] SEL_TORQUE_REF = 8'h02;
	localparam logic [7:0] SEL_POS_ERR    = 8'h03;
	localparam logic [7:0] SEL_AMP_ERR    = 8'h04;
	localparam logic [7:0] SEL_POS_REF_SP = 8'h05;
	localparam logic [7:0] SEL_RESERVED   = 8'h06;
	localparam logic [7:0] SEL_LOAD_ERR   = 8'h07;
	localparam logic [7:0] SEL_POS_DONE   = 8'h08;
	localparam logic [7:0] SEL_SPEED_FF   = 8'h09;
	localparam logic [7:0] SEL_TORQUE_FF  = 8'h0a;
	localparam logic [7:0] SEL_GAIN_SET   = 8'h0b;
	localparam logic [7:0] SEL_REF_DONE   = 8'h0c;
	localparam logic [7:0] SEL_EXT_SPEED  = 8'h0d;

	// Millivolts per input unit of each signal kind, and fixed millivolt levels for the flags and the gain set
	localparam int MV_PER_RPM      = 1;
	localparam int MV_PER_TORQUE   = 1;
	localparam int MV_PER_REF_UNIT = 50;
	localparam int MV_PER_PULSE    = 50;
	localparam int MV_PER_LOAD_REF = 10;
	localparam int MV_LEVEL_HIGH   = 5000;
	localparam int MV_GAIN_ONE     = 1000;
	localparam int MV_GAIN_TWO     = 2000;

	// Offset step is 0.1 V, expressed in 0.01 mV of the scaled sum
	localparam int OFFS_STEP_CMV = 10000;
	// Sum in 0.01 mV to code: times 983 then shift 15, about 3 codes per mV
	localparam int CODE_GAIN  = 983;
	localparam int CODE_SHIFT = 15;
	localparam logic signed [15:0] CODE_MAX = 16'sh7fff;
	localparam logic signed [15:0] CODE_MIN = -16'sh8000;

	// Output update period
	localparam int CLOCK_MHZ      = 200;
	localparam int UPDATE_NS      = 1000;
	localparam int UPDATE_CYCLES  = UPDATE_NS * CLOCK_MHZ / 1000;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : amss_pkg

/* File: bench/amss_properties.sv */
// Port checks for the analog monitor block
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module amss_properties #(
	parameter int UPDATE_CYCLES = 4
) (
	input wire logic        ref_clk,
	input wire logic        reset_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        dacValid,
	input wire logic        dacReady,
	input wire logic [31:0] dacCodes
);
	// Tick, push edge and one spare cycle
	localparam int WAIT_MAX = UPDATE_CYCLES + 2;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write not answered");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_read_refuse: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
	a_write_refuse: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken early");
	a_b_release: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response held");
	a_unmapped_read: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
	a_code_stands: assert property (
		dacValid && !dacReady |=> dacValid && $stable(dacCodes))
		else $error("code changed before taken");
	a_update_rate: assert property (
		!dacValid |-> ##[1:WAIT_MAX] dacValid)
		else $error("no output update");
endmodule : amss_properties

bind amss_monitor amss_properties #(.UPDATE_CYCLES(UPDATE_CYCLES)) props (
	.ref_clk(ref_clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .dacValid(dacValid),
	.dacReady(dacReady), .dacCodes(dacCodes));
`default_nettype wire

/* File: bench/amss_recorder.sv */
// Converter-side recorder model that takes codes, with stalls
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module amss_recorder (
	input  wire logic ref_clk,
	input  wire logic reset_n,
	input  wire logic stall,
	output logic      dacReady
);
	logic phase;
	// Half rate still outruns the update rate, so the FIFO drains
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			phase <= 1'b0;
		else
			phase <= ~phase;
	end
	assign dacReady = phase && !stall;
endmodule : amss_recorder
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the analog monitor block
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module testbench;
	localparam logic [31:0] RESETS [6] = '{32'h2, 32'h0, 32'h0, 32'h0,
		32'h64, 32'h64};
	logic        ref_clk, reset_n, s_axi_awvalid, s_axi_wvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_rready, stall, armed;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, dacValid, dacReady;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, dacCodes, seed;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic signed [15:0] sv [10];
	logic [4:0]  fl;
	int          err_count, samples_checked, sel [2], mult [2], offs [2];

	amss_monitor #(.UPDATE_CYCLES(4)) dut (
		.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .motorSpeed(sv[0]),
		.speedRef(sv[1]), .torqueRef(sv[2]), .positionError(sv[3]),
		.positionAmpError(sv[4]), .positionRefSpeed(sv[5]),
		.torqueFeedforward(sv[6]), .loadPositionError(sv[7]),
		.externalSpeed(sv[8]), .speedFeedforward(sv[9]),
		.positioningDone(fl[0]), .referenceDone(fl[1]),
		.secondGainActive(fl[2]), .positionControl(fl[3]),
		.fullyClosedLoop(fl[4]), .dacValid, .dacReady, .dacCodes);
	amss_recorder rec (.ref_clk, .reset_n, .stall, .dacReady);

	////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
		return seed;
	endfunction : rnd

	// Selected signal in millivolts
	function automatic longint mv(int s);
		case (s)
			0, 1, 2, 5, 9: return sv[s];
			3: return fl[3] ? 50 * sv[3] : 0;
			4: return 50 * sv[4];
			7: return 10 * sv[7];
			8: return fl[0] ? 5000 : 0;
			10: return sv[6];
			11: return fl[2] ? 2000 : 1000;
			12: return fl[1] ? 5000 : 0;
			13: return fl[4] ? sv[8] : 0;
			default: return 0;
		endcase
	endfunction : mv

	function automatic logic [31:0] code(int c);
		longint p;
		p = -(mv(sel[c]) * mult[c] + 10000 * longint'(offs[c])) * 983 >>> 15;
		if (p > 32767)
			p = 32767;
		if (p < -32768)
			p = -32768;
		return {16'h0, p[15:0]};
	endfunction : code

	task automatic check(input logic [31:0] seen, exp, input string nm);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic       awTake, wTake, done;
		logic [1:0] resp;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		repeat (200) begin
			// Falling edge: handshake settled, same as at the next rise
			@(negedge ref_clk);
			awTake = s_axi_awvalid && s_axi_awready === 1'b1;
			wTake = s_axi_wvalid && s_axi_wready === 1'b1;
			done = s_axi_bvalid === 1'b1;
			resp = done ? s_axi_bresp : 2'hx;
			@(posedge ref_clk);
			if (awTake)
				s_axi_awvalid <= 1'b0;
			if (wTake)
				s_axi_wvalid <= 1'b0;
			if (done)
				break;
		end
		check({30'h0, resp}, {30'h0, er}, "write response");
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic        arTake, done;
		logic [31:0] data;
		logic [1:0]  resp;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		repeat (200) begin
			@(negedge ref_clk);
			arTake = s_axi_arvalid && s_axi_arready === 1'b1;
			done = s_axi_rvalid === 1'b1;
			data = done ? s_axi_rdata : 32'hx;
			resp = done ? s_axi_rresp : 2'hx;
			@(posedge ref_clk);
			if (arTake)
				s_axi_arvalid <= 1'b0;
			if (done)
				break;
		end
		check(data, ed, "read data");
		check({30'h0, resp}, {30'h0, er}, "read response");
	endtask : rd

	// Old words drain before comparing, as settings act per update
	task automatic run_case(input int s0, s1, m0, m1, o0, o1);
		armed = 1'b0;
		sel = '{s0, s1};
		mult = '{m0, m1};
		offs = '{o0, o1};
		wr(amss_pkg::ADDR_SEL_ONE, 32'(s0), 2'h0);
		wr(amss_pkg::ADDR_SEL_TWO, 32'(s1), 2'h0);
		wr(amss_pkg::ADDR_MULT_ONE, 32'(m0), 2'h0);
		wr(amss_pkg::ADDR_MULT_TWO, 32'(m1), 2'h0);
		wr(amss_pkg::ADDR_OFFS_ONE, 32'(o0), 2'h0);
		wr(amss_pkg::ADDR_OFFS_TWO, 32'(o1), 2'h0);
		for (int i = 0; i < 10; i++)
			sv[i] <= 16'(rnd());
		fl <= 5'(rnd());
		repeat (80) @(posedge ref_clk);
		armed = 1'b1;
		repeat (40) @(posedge ref_clk);
		rd(amss_pkg::ADDR_LAST_CODES, (code(1) << 16) | code(0), 2'h0);
	endtask : run_case

	task automatic print_verdict();
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////
	// Falling edge: the word and its handshake are settled here
	always @(negedge ref_clk) begin
		if (armed && dacValid === 1'b1 && dacReady === 1'b1) begin
			check({16'h0, dacCodes[15:0]}, code(0), "code one");
			check({16'h0, dacCodes[31:16]}, code(1), "code two");
		end
	end

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		#100000;
		err_count++;
		print_verdict();
	end

	initial begin
		{reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_bready, s_axi_rready, stall, armed} = 4'hc;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		for (int i = 0; i < 10; i++)
			sv[i] = 16'h0;
		fl = 5'h0;
		seed = 32'hb2bc2f2d;
		err_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < 6; i++)
			rd(8'(4 * i), RESETS[i], 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		wr(amss_pkg::ADDR_LAST_CODES, 32'h1, 2'h2);
		wr(amss_pkg::ADDR_MULT_ONE, 32'h7fff, 2'h0);
		rd(amss_pkg::ADDR_MULT_ONE, 32'h2710, 2'h0);
		wr(amss_pkg::ADDR_OFFS_TWO, 32'hb1e0, 2'h0);
		rd(amss_pkg::ADDR_OFFS_TWO, 32'hd8f0, 2'h0);
		run_case(2, 0, 100, 100, 0, 0);
		for (int c = 0; c < 14; c++)
			if (c != 6)
				run_case(c, c == 7 ? 0 : 13 - c,
					int'(rnd() % 20001) - 10000,
					int'(rnd() % 20001) - 10000,
					int'(rnd() % 20001) - 10000,
					int'(rnd() % 20001) - 10000);
		stall <= 1'b1;
		repeat (60) @(posedge ref_clk);
		rd(amss_pkg::ADDR_STATUS, 32'h80000008, 2'h0);
		stall <= 1'b0;
		repeat (60) @(posedge ref_clk);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
